// >>> src/i2c_bit_engine.sv
// bit engine: start, stop and single bits on open-drain scl and sda
`include "i2c_master_map.svh"
module i2c_bit_engine
	import i2c_master_pkg::*;
(
	input  wire logic clk_sys,
	input  wire logic reset,
	i2c_bit_if.eng    link,
	input  wire logic scl_i,
	output logic      scl_o,
	output logic      scl_oe,
	input  wire logic sda_i,
	output logic      sda_o,
	output logic      sda_oe
);
	engine_state_t cur;
	engine_state_t next;

	// pins only ever pull low
	assign scl_o          = 1'b0;
	assign sda_o          = 1'b0;
	assign scl_oe         = cur.scl_low;
	assign sda_oe         = cur.sda_low;
	assign link.ready     = !cur.busy || (cur.cnt == `SCL_LAST);
	assign link.done      = cur.busy && (cur.cnt == `DONE_PT);
	assign link.rbit      = cur.rbit;
	assign link.scl_rise  = cur.rise;
	assign link.stop_seen = cur.scl_s2 && cur.sda_s2 && !cur.sda_prev;

	// bit timing, pin drive and input synchronisers
	always_comb begin
		next          = cur;
		next.rise     = 1'b0;
		next.scl_s1   = scl_i;
		next.scl_s2   = cur.scl_s1;
		next.sda_s1   = sda_i;
		next.sda_s2   = cur.sda_s1;
		next.sda_prev = cur.sda_s2;
		if (cur.busy) begin
			next.cnt = cur.cnt + 6'h01;
		end
		if (cur.busy && (cur.cnt == `SCL_LAST)) begin
			next.busy = 1'b0;
		end
		if (link.cmd_valid && link.ready) begin
			next.busy = 1'b1;
			next.cnt  = 6'h00;
			next.cmd  = link.cmd;
			next.wbit = link.wbit;
		end
		if (cur.busy && (cur.cnt == `SCL_SAMPLE)) begin
			next.rbit = cur.sda_s2;
		end
		// scl low for the first half of every bit and of the stop
		next.scl_low = next.busy && (next.cmd != CMD_START) && (next.cnt < `SCL_HALF);
		next.rise    = next.busy && ((next.cmd == CMD_WRITE) || (next.cmd == CMD_READ))
			&& (next.cnt == `SCL_HALF);
		// sda moves a fixed delay after the scl fall, except the start fall and the stop release while scl is high
		if (next.busy) begin
			case (next.cmd)
				CMD_START: begin
					if (next.cnt == `SCL_HALF) begin
						next.sda_low = 1'b1;
					end
				end
				CMD_WRITE: begin
					if (next.cnt == `SDA_DELAY) begin
						next.sda_low = !next.wbit;
					end
				end
				CMD_READ: begin
					if (next.cnt == `SDA_DELAY) begin
						next.sda_low = 1'b0;
					end
				end
				CMD_STOP: begin
					if (next.cnt == `SDA_DELAY) begin
						next.sda_low = 1'b1;
					end else if (next.cnt == `SCL_SAMPLE) begin
						next.sda_low = 1'b0;
					end
				end
				default: begin
					next.sda_low = 1'b0;
				end
			endcase
		end
	end

	// state register
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			cur <= '0;
		end else begin
			cur <= next;
		end
	end

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (reset);

	a_scl_low_half: assert property ($rose(scl_oe) |-> (cur.cnt == 6'h00) ##27 scl_oe ##1 !scl_oe)
		else $error("scl low phase is not half the divided period");
	a_sda_delay: assert property (($changed(sda_oe) && (cur.cmd == CMD_WRITE)) |-> $past(scl_oe, 3) && scl_oe && (cur.cnt == `SDA_DELAY))
		else $error("sda changed other than three cycles after scl fall");
endmodule

// >>> src/i2c_bit_if.sv
// command link between the transfer sequencer and the bit engine
interface i2c_bit_if;
	import i2c_master_pkg::*;
	logic     cmd_valid;
	bus_cmd_t cmd;
	logic     wbit;
	logic     ready;
	logic     done;
	logic     rbit;
	logic     scl_rise;
	logic     stop_seen;
	modport ctrl (output cmd_valid, cmd, wbit, input ready, done, rbit, scl_rise, stop_seen);
	modport eng  (input cmd_valid, cmd, wbit, output ready, done, rbit, scl_rise, stop_seen);
endinterface

// >>> src/i2c_master_map.svh
// register offsets, field positions, reset values and bit timing of the i2c master
`ifndef I2C_MASTER_MAP_SVH
`define I2C_MASTER_MAP_SVH
// register byte offsets
`define OFS_CTRL       8'h00
`define OFS_STATUS     8'h04
`define OFS_INT_STATUS 8'h08
`define OFS_INT_MASK   8'h0c
`define OFS_SLAVE_ADDR 8'h10
`define OFS_TX_DATA    8'h14
`define OFS_RX_DATA    8'h18
// field positions
`define CTRL_RUN       0
`define STAT_BUSY      0
`define STAT_ACK       1
`define STAT_DIR       2
`define EV_TX_END      0
`define EV_RX_FULL     1
`define EV_STOP        2
`define EV_NACK        3
// reset values
`define RUN_RST        1'h0
`define MASK_RST       4'h0
`define ADDR_RST       7'h00
`define TX_RST         24'h000000
// bus answers
`define RESP_OKAY      2'h0
`define RESP_SLVERR    2'h2
// bytes per transfer, last byte index
`define XFER_LAST      2'h2
// serial bit timing in peripheral base clock cycles
`define SCL_DIV        6'h38
`define SCL_LAST       (`SCL_DIV - 6'h01)
`define SCL_HALF       (`SCL_DIV >> 1)
`define SCL_SAMPLE     (`SCL_HALF + (`SCL_HALF >> 1))
`define SDA_DELAY      6'h03
`define DONE_LEAD      6'h02
`define DONE_PT        (`SCL_LAST - `DONE_LEAD)
`endif

// >>> src/i2c_master_pkg.sv
// types shared by the i2c master and its bit engine
package i2c_master_pkg;
	typedef enum logic [1:0] {CMD_START, CMD_STOP, CMD_WRITE, CMD_READ} bus_cmd_t;
	typedef enum logic [2:0] {
		ST_IDLE  = 3'h0,
		ST_START = 3'h1,
		ST_BYTE  = 3'h3,
		ST_ACK   = 3'h2,
		ST_STOP  = 3'h6
	} master_st_t;
	typedef struct packed {
		logic [5:0] cnt;
		logic       busy;
		bus_cmd_t   cmd;
		logic       wbit;
		logic       rbit;
		logic       rise;
		logic       scl_low;
		logic       sda_low;
		logic       scl_s1;
		logic       scl_s2;
		logic       sda_s1;
		logic       sda_s2;
		logic       sda_prev;
	} engine_state_t;
endpackage

// >>> src/i2c_single_master_txrx.sv
// i2c single master: alternating three-byte write and read transfers behind axi4-lite
// Behaviour
// - every transfer opens with the 7-bit slave address plus a direction bit
// - serial clock is the peripheral base clock divided by 56
// - sole master on the bus, no arbitration logic
// - no repeated start; each transfer ends with stop before next start
// - write three bytes, then read three bytes, alternating forever
// - no wait states: ack clock follows the eighth data bit directly
// - all bytes shifted msb first on sda
// - sda changes three base clock cycles after the scl edge
// - slave ack of the ninth clock is kept in a readable flag
// - separate transmit-end, receive-full, stop-detected and nack events; others absent
// - transmit-end or receive-full raised on the rising ninth scl edge
// - direction bit is 0 for write, 1 for read
// - at the end: data events off, stop generated, stop event on
// - after stop detection return to idle with bus events off
`include "i2c_master_map.svh"
module i2c_single_master_txrx
	import i2c_master_pkg::*;
(
	input  wire logic        clk_sys,
	input  wire logic        reset,
	input  wire logic        awvalid,
	output logic             awready,
	input  wire logic [7:0]  awaddr,
	input  wire logic        wvalid,
	output logic             wready,
	input  wire logic [31:0] wdata,
	input  wire logic [3:0]  wstrb,
	output logic             bvalid,
	input  wire logic        bready,
	output logic [1:0]       bresp,
	input  wire logic        arvalid,
	output logic             arready,
	input  wire logic [7:0]  araddr,
	output logic             rvalid,
	input  wire logic        rready,
	output logic [31:0]      rdata,
	output logic [1:0]       rresp,
	output logic             irq,
	input  wire logic        scl_i,
	output logic             scl_o,
	output logic             scl_oe,
	input  wire logic        sda_i,
	output logic             sda_o,
	output logic             sda_oe
);
	typedef struct packed {
		logic        aw_held;
		logic [7:0]  aw_addr;
		logic        w_held;
		logic [31:0] wdata;
		logic [3:0]  wstrb;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
		logic        run;
		logic [6:0]  slave_addr;
		logic [23:0] transmit_data_reg;
		logic [23:0] receive_data_reg;
		logic [3:0]  int_status;
		logic [3:0]  int_mask;
		logic        received_ack_flag;
		master_st_t  st;
		logic        dir;
		logic        data_phase;
		logic [2:0]  bit_cnt;
		logic [1:0]  byte_cnt;
		logic [7:0]  shreg;
		logic        issue;
		bus_cmd_t    cmd;
		logic        wbit;
		logic        xfer_en;
		logic        stop_en;
	} master_state_t;

	master_state_t cur;
	master_state_t next;
	logic [3:0]    ev;
	logic [3:0]    clr;
	logic [31:0]   wmerge;
	logic [31:0]   old_word;
	logic          do_wr;
	logic          reading;
	logic [1:0]    nb;
	logic [7:0]    txb;
	i2c_bit_if     link ();

	// byte-lane merge of a register write
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
		input logic [3:0] strb);
		logic [31:0] res;
		res = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				res[8*i +: 8] = wd[8*i +: 8];
			end
		end
		return res;
	endfunction

	// bus handshakes and pins
	assign awready        = !cur.aw_held && !cur.bvalid;
	assign wready         = !cur.w_held && !cur.bvalid;
	assign arready        = !cur.rvalid;
	assign bvalid         = cur.bvalid;
	assign bresp          = cur.bresp;
	assign rvalid         = cur.rvalid;
	assign rdata          = cur.rdata;
	assign rresp          = cur.rresp;
	assign irq            = |(cur.int_status & cur.int_mask);
	assign link.cmd_valid = cur.issue;
	assign link.cmd       = cur.cmd;
	assign link.wbit      = cur.wbit;
	assign do_wr          = cur.aw_held && cur.w_held && !cur.bvalid;
	assign reading        = cur.dir && cur.data_phase;
	assign nb             = cur.data_phase ? (cur.byte_cnt + 2'h1) : 2'h0;
	assign txb            = cur.transmit_data_reg[{nb, 3'h0} +: 8];

	// serial timing and pins; the sole master never watches for lost arbitration
	i2c_bit_engine u_engine (
		.clk_sys (clk_sys),
		.reset   (reset),
		.link    (link),
		.scl_i   (scl_i),
		.scl_o   (scl_o),
		.scl_oe  (scl_oe),
		.sda_i   (sda_i),
		.sda_o   (sda_o),
		.sda_oe  (sda_oe)
	);

	// old contents of the addressed register for byte-lane merging
	always_comb begin
		case (cur.aw_addr)
			`OFS_CTRL:       old_word = {31'h0, cur.run};
			`OFS_INT_MASK:   old_word = {28'h0, cur.int_mask};
			`OFS_SLAVE_ADDR: old_word = {25'h0, cur.slave_addr};
			`OFS_TX_DATA:    old_word = {8'h0, cur.transmit_data_reg};
			default:         old_word = 32'h0;
		endcase
		wmerge = merge(old_word, cur.wdata, cur.wstrb);
	end

	// register file, transfer sequencer and event flags
	always_comb begin
		next = cur;
		ev   = 4'h0;
		clr  = 4'h0;
		// write address and data are taken in either order
		if (awvalid && awready) begin
			next.aw_held = 1'b1;
			next.aw_addr = awaddr;
		end
		if (wvalid && wready) begin
			next.w_held = 1'b1;
			next.wdata  = wdata;
			next.wstrb  = wstrb;
		end
		if (cur.bvalid && bready) begin
			next.bvalid = 1'b0;
		end
		if (do_wr) begin
			next.aw_held = 1'b0;
			next.w_held  = 1'b0;
			next.bvalid  = 1'b1;
			next.bresp   = `RESP_OKAY;
			case (cur.aw_addr)
				`OFS_CTRL:       next.run = wmerge[`CTRL_RUN];
				`OFS_INT_STATUS: clr = cur.wdata[3:0] & {4{cur.wstrb[0]}};
				`OFS_INT_MASK:   next.int_mask = wmerge[3:0];
				`OFS_SLAVE_ADDR: next.slave_addr = wmerge[6:0];
				`OFS_TX_DATA:    next.transmit_data_reg = wmerge[23:0];
				`OFS_STATUS, `OFS_RX_DATA: next.bresp = `RESP_OKAY;
				default:         next.bresp = `RESP_SLVERR;
			endcase
		end
		// read port answers in the cycle after the address is taken
		if (cur.rvalid && rready) begin
			next.rvalid = 1'b0;
		end
		if (arvalid && arready) begin
			next.rvalid = 1'b1;
			next.rresp  = `RESP_OKAY;
			next.rdata  = 32'h0;
			case (araddr)
				`OFS_CTRL:       next.rdata[`CTRL_RUN] = cur.run;
				`OFS_STATUS: begin
					next.rdata[`STAT_BUSY] = cur.st != ST_IDLE;
					next.rdata[`STAT_ACK]  = cur.received_ack_flag;
					next.rdata[`STAT_DIR]  = cur.dir;
				end
				`OFS_INT_STATUS: next.rdata[3:0] = cur.int_status;
				`OFS_INT_MASK:   next.rdata[3:0] = cur.int_mask;
				`OFS_SLAVE_ADDR: next.rdata[6:0] = cur.slave_addr;
				`OFS_TX_DATA:    next.rdata[23:0] = cur.transmit_data_reg;
				`OFS_RX_DATA:    next.rdata[23:0] = cur.receive_data_reg;
				default:         next.rresp = `RESP_SLVERR;
			endcase
		end
		// a command is dropped from the link once the engine takes it
		if (cur.issue && link.ready) begin
			next.issue = 1'b0;
		end
		// stop seen on the bus ends the stop window
		if (link.stop_seen && cur.stop_en) begin
			ev[`EV_STOP] = 1'b1;
			next.stop_en = 1'b0;
		end
		case (cur.st)
			ST_IDLE: begin
				if (cur.run && !cur.stop_en) begin
					next.st         = ST_START;
					next.issue      = 1'b1;
					next.cmd        = CMD_START;
					next.xfer_en    = 1'b1;
					next.data_phase = 1'b0;
					next.byte_cnt   = 2'h0;
					next.bit_cnt    = 3'h0;
					next.shreg      = {cur.slave_addr, cur.dir};
				end
			end
			ST_START: begin
				if (link.done) begin
					next.st    = ST_BYTE;
					next.issue = 1'b1;
					next.cmd   = CMD_WRITE;
					next.wbit  = cur.shreg[7];
				end
			end
			ST_BYTE: begin
				if (link.done) begin
					next.shreg = {cur.shreg[6:0], reading ? link.rbit : 1'b0};
					next.issue = 1'b1;
					if (cur.bit_cnt == 3'h7) begin
						next.st      = ST_ACK;
						next.bit_cnt = 3'h0;
						next.cmd     = reading ? CMD_WRITE : CMD_READ;
						next.wbit    = !reading || (cur.byte_cnt == `XFER_LAST);
					end else begin
						next.bit_cnt = cur.bit_cnt + 3'h1;
						next.cmd     = reading ? CMD_READ : CMD_WRITE;
						next.wbit    = cur.shreg[6];
					end
				end
			end
			ST_ACK: begin
				if (link.scl_rise && cur.xfer_en) begin
					if (reading) begin
						ev[`EV_RX_FULL] = 1'b1;
						next.receive_data_reg[{cur.byte_cnt, 3'h0} +: 8] = cur.shreg;
					end else begin
						ev[`EV_TX_END] = 1'b1;
					end
				end
				if (link.done) begin
					next.issue = 1'b1;
					if (!reading) begin
						next.received_ack_flag = link.rbit;
					end
					if ((!reading && link.rbit) ||
						(cur.data_phase && (cur.byte_cnt == `XFER_LAST))) begin
						ev[`EV_NACK] = !reading && link.rbit;
						next.st      = ST_STOP;
						next.cmd     = CMD_STOP;
						next.xfer_en = 1'b0;
						next.stop_en = 1'b1;
					end else begin
						next.st         = ST_BYTE;
						next.data_phase = 1'b1;
						next.byte_cnt   = nb;
						next.shreg      = cur.dir ? 8'h00 : txb;
						next.cmd        = cur.dir ? CMD_READ : CMD_WRITE;
						next.wbit       = cur.dir || txb[7];
					end
				end
			end
			ST_STOP: begin
				if (link.done) begin
					next.st  = ST_IDLE;
					next.dir = !cur.dir;
				end
			end
			default: begin
				next.st = ST_IDLE;
			end
		endcase
		// sticky flags: a new event wins over a clear in the same cycle
		next.int_status = (cur.int_status & ~clr) | ev;
	end

	// state register
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			cur                   <= '0;
			cur.run               <= `RUN_RST;
			cur.int_mask          <= `MASK_RST;
			cur.slave_addr        <= `ADDR_RST;
			cur.transmit_data_reg <= `TX_RST;
		end else begin
			cur <= next;
		end
	end

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (reset);

	sequence s_last_data_bit;
		(cur.st == ST_BYTE) && link.done && (cur.bit_cnt == 3'h7);
	endsequence
	sequence s_ack_issued;
		(cur.st == ST_ACK) && cur.issue ##[0:2] (cur.issue && link.ready);
	endsequence
	sequence s_nack_seen;
		(cur.st == ST_ACK) && link.done && !reading && link.rbit;
	endsequence

	a_ack_no_wait: assert property (s_last_data_bit |=> s_ack_issued)
		else $error("ack clock not issued right after eighth bit");
	a_start_from_idle: assert property ($rose(cur.st == ST_START) |-> $past(cur.st) == ST_IDLE)
		else $error("start issued outside idle");
	a_stop_window: assert property ($rose(cur.st == ST_STOP) |-> !cur.xfer_en && cur.stop_en)
		else $error("event enables wrong while stopping");
	a_idle_quiet: assert property ($fell(cur.stop_en) |-> !cur.xfer_en ##[0:16]
		(cur.st == ST_IDLE))
		else $error("no return to idle after stop detection");
	a_nack_abort: assert property (s_nack_seen |=> (cur.st == ST_STOP) && cur.int_status[`EV_NACK])
		else $error("nack did not abort with error flag");
	a_last_nack: assert property (((cur.st == ST_ACK) && cur.issue && reading) |->
		cur.wbit == (cur.byte_cnt == `XFER_LAST))
		else $error("read ack level wrong for byte position");
	a_dir_bit: assert property (((cur.st == ST_BYTE) && !cur.data_phase && (cur.bit_cnt == 3'h7)
		&& cur.issue) |-> cur.wbit == cur.dir)
		else $error("direction bit does not match transfer kind");
	a_event_edge: assert property ($rose(cur.int_status[`EV_TX_END]) |-> $past(link.scl_rise))
		else $error("transmit end not tied to ninth scl rise");
	a_dir_toggle: assert property (($past(cur.st) == ST_STOP && cur.st == ST_IDLE) |->
		cur.dir != $past(cur.dir))
		else $error("transfer direction did not alternate");
	a_ack_flag: assert property (s_nack_seen |=> cur.received_ack_flag)
		else $error("received ack flag not updated");
endmodule

// >>> verification/i2c_single_master_txrx_test.sv
// testbench: i2c master driven over axi4-lite against the slave model
`include "i2c_master_map.svh"
module i2c_single_master_txrx_test;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk_sys = 1'h0;
	logic        reset = 1'h1;
	logic        awvalid = 1'h0;
	logic [7:0]  awaddr = 8'h00;
	logic        wvalid = 1'h0;
	logic [31:0] wdata = 32'h0;
	logic [3:0]  wstrb = 4'h0;
	logic [3:0]  strb = 4'hf;
	logic        scl_out, sda_out;
	logic        bready = 1'h0;
	logic        arvalid = 1'h0;
	logic [7:0]  araddr = 8'h00;
	logic        rready = 1'h0;
	logic        awready, wready, bvalid, arready, rvalid, irq;
	logic [1:0]  bresp, rresp, r;
	logic [31:0] rdata, v;
	logic        scl_oe, sda_oe, slave_oe;
	logic        refuse = 1'h0;
	logic [6:0]  addr = 7'h00;
	logic [23:0] tx, rb, got;
	logic [7:0]  got_addr;
	logic [2:0]  acks;
	int          lag = 0;
	int          fails = 0;
	int          num_checks = 0;
	time         t_low, t0;
	wire         scl = !scl_oe;
	wire         sda = !(sda_oe || slave_oe);
	always #4 clk_sys = !clk_sys;
	i2c_single_master_txrx dut_u (.clk_sys, .reset, .awvalid, .awready, .awaddr, .wvalid,
		.wready, .wdata, .wstrb, .bvalid, .bready, .bresp, .arvalid, .arready, .araddr,
		.rvalid, .rready, .rdata, .rresp, .irq, .scl_i(scl), .scl_o(scl_out), .scl_oe,
		.sda_i(sda), .sda_o(sda_out), .sda_oe);
	i2c_slave_model slave_u (.scl, .sda, .addr, .refuse, .read_bytes(rb), .lag,
		.sda_oe(slave_oe), .got_addr, .got, .acks);
	task automatic check(input logic [31:0] g, input logic [31:0] e);
		num_checks++;
		if (g !== e) begin
			fails++;
			$display("CHECK FAILED at %0t got %h expected %h", $time, g, e);
		end
	endtask
	task automatic results;
		$display("checks %0d mismatches %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		int   n;
		logic ta;
		logic tw;
		@(posedge clk_sys);
		awvalid <= 1'h1;
		awaddr  <= a;
		wvalid  <= 1'h1;
		wdata   <= d;
		wstrb   <= strb;
		bready  <= 1'h1;
		for (n = 0; n < 64; n++) begin
			@(negedge clk_sys);
			if (bvalid) break;
			ta = awvalid && awready;
			tw = wvalid && wready;
			@(posedge clk_sys);
			if (ta) awvalid <= 1'h0;
			if (tw) wvalid <= 1'h0;
		end
		check({29'h0, bvalid, bresp}, {29'h0, 1'h1, er});
		@(posedge clk_sys);
		bready <= 1'h0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] er);
		int   n;
		logic ta;
		@(posedge clk_sys);
		arvalid <= 1'h1;
		araddr  <= a;
		rready  <= 1'h1;
		for (n = 0; n < 64; n++) begin
			@(negedge clk_sys);
			if (rvalid) break;
			ta = arvalid && arready;
			@(posedge clk_sys);
			if (ta) arvalid <= 1'h0;
		end
		d = rdata;
		er = rvalid ? rresp : 2'h3;
		@(posedge clk_sys);
		rready <= 1'h0;
	endtask
	task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
		rd(a, v, r);
		check(v, e);
		check({30'h0, r}, {30'h0, er});
	endtask
	task automatic wait_bit(input logic [7:0] a, input int b, input logic val);
		int n;
		for (n = 0; n < 4000; n++) begin
			rd(a, v, r);
			if (v[b] === val) break;
		end
		check({31'h0, v[b]}, {31'h0, val});
	endtask
	task automatic irq_is(input logic e);
		@(negedge clk_sys);
		check({31'h0, irq}, {31'h0, e});
	endtask
	// data from the master must move a fixed lag after scl is pulled low
	always @(posedge scl_oe) t_low = $time;
	always @(sda_oe) begin
		if (!reset && scl_oe) check(32'($time - t_low), 32'h18);
	end
	// watchdog: the whole run needs well under this span
	initial begin
		#(90000 * 8);
		fails++;
		results;
	end
	initial begin
		void'($urandom(32'h8589));
		addr = 7'($urandom);
		tx = 24'($urandom);
		rb = {8'h80, 16'($urandom)};
		repeat (6) @(posedge clk_sys);
		reset <= 1'h0;
		// reset values, unmapped and read-only places
		rd_chk(`OFS_CTRL, 32'h0, `RESP_OKAY);
		rd_chk(`OFS_INT_MASK, 32'h0, `RESP_OKAY);
		rd_chk(`OFS_SLAVE_ADDR, 32'h0, `RESP_OKAY);
		rd_chk(`OFS_TX_DATA, 32'h0, `RESP_OKAY);
		rd_chk(`OFS_STATUS, 32'h0, `RESP_OKAY);
		rd_chk(8'h1c, 32'h0, `RESP_SLVERR);
		wr(8'h1c, 32'h1, `RESP_SLVERR);
		wr(`OFS_STATUS, 32'h7, `RESP_OKAY);
		rd_chk(`OFS_STATUS, 32'h0, `RESP_OKAY);
		irq_is(1'h0);
		$display("test reset_map done");
		// write transfer then read transfer
		wr(`OFS_SLAVE_ADDR, {25'h0, addr}, `RESP_OKAY);
		// transmit data goes in one byte lane at a time
		for (int i = 0; i < 3; i++) begin
			strb = 4'h1 << i;
			wr(`OFS_TX_DATA, {8'h0, tx}, `RESP_OKAY);
		end
		strb = 4'hf;
		rd_chk(`OFS_TX_DATA, {8'h0, tx}, `RESP_OKAY);
		wr(`OFS_INT_MASK, 32'h7, `RESP_OKAY);
		rd_chk(`OFS_INT_MASK, 32'h7, `RESP_OKAY);
		wr(`OFS_CTRL, 32'h1, `RESP_OKAY);
		@(posedge scl);
		t0 = $time;
		@(posedge scl);
		check(32'($time - t0), 32'h1c0);
		wait_bit(`OFS_INT_STATUS, `EV_STOP, 1'h1);
		check({24'h0, got_addr}, {24'h0, addr, 1'h0});
		check({8'h0, got}, {8'h0, tx});
		rd(`OFS_INT_STATUS, v, r);
		check(v & 32'h5, 32'h5);
		irq_is(1'h1);
		rd(`OFS_STATUS, v, r);
		check(v & 32'h2, 32'h0);
		lag = 160;
		wr(`OFS_INT_STATUS, 32'h7, `RESP_OKAY);
		irq_is(1'h0);
		wait_bit(`OFS_INT_STATUS, `EV_STOP, 1'h1);
		check({24'h0, got_addr}, {24'h0, addr, 1'h1});
		rd_chk(`OFS_RX_DATA, {8'h0, rb}, `RESP_OKAY);
		check({29'h0, acks}, 32'h4);
		rd(`OFS_INT_STATUS, v, r);
		check(v & 32'h3, 32'h3);
		wr(`OFS_CTRL, 32'h0, `RESP_OKAY);
		wait_bit(`OFS_STATUS, `STAT_BUSY, 1'h0);
		@(negedge clk_sys);
		check({28'h0, scl_out, sda_out, scl_oe, sda_oe}, 32'h0);
		wr(`OFS_INT_STATUS, 32'hf, `RESP_OKAY);
		irq_is(1'h0);
		$display("test write_read done");
		// slave refuses its address, event masked then unmasked
		refuse = 1'h1;
		wr(`OFS_INT_MASK, 32'h0, `RESP_OKAY);
		wr(`OFS_CTRL, 32'h1, `RESP_OKAY);
		wait_bit(`OFS_INT_STATUS, `EV_NACK, 1'h1);
		irq_is(1'h0);
		rd(`OFS_STATUS, v, r);
		check(v & 32'h2, 32'h2);
		wr(`OFS_CTRL, 32'h0, `RESP_OKAY);
		wait_bit(`OFS_STATUS, `STAT_BUSY, 1'h0);
		wr(`OFS_INT_MASK, 32'h8, `RESP_OKAY);
		irq_is(1'h1);
		wr(`OFS_INT_STATUS, 32'hf, `RESP_OKAY);
		irq_is(1'h0);
		$display("test nack done");
		results;
	end
endmodule

// >>> verification/i2c_slave_model.sv
// i2c slave model on the open-drain bus, acks writes and serves read bytes
module i2c_slave_model (
	input  wire logic        scl,
	input  wire logic        sda,
	input  wire logic [6:0]  addr,
	input  wire logic        refuse,
	input  wire logic [23:0] read_bytes,
	input  int               lag,
	output logic             sda_oe,
	output logic [7:0]       got_addr,
	output logic [23:0]      got,
	output logic [2:0]       acks
);
	timeunit 1ns;
	timeprecision 1ps;
	int         bits;
	int         idx;
	logic [7:0] sh;
	logic       active;
	logic       rd;
	logic       addr_ph;
	initial begin
		sda_oe = 1'h0;
		active = 1'h0;
	end
	// start: sda falls while scl is high
	always @(negedge sda) begin
		if (scl) begin
			active = 1'h1;
			addr_ph = 1'h1;
			rd = 1'h0;
			bits = 0;
			idx = 0;
		end
	end
	// stop: sda rises while scl is high, bus released
	always @(posedge sda) begin
		if (scl) begin
			active = 1'h0;
		end
	end
	// sample data msb first and the master's ack on rising scl
	always @(posedge scl) begin
		if (active) begin
			if (bits < 8) sh = {sh[6:0], sda};
			else if (rd && idx > 0) acks[idx - 1] = sda;
			bits++;
		end
	end
	// drive only while scl is low; lag lets the answer come late
	always @(negedge scl) begin
		if (active) begin
			if (bits == 8 && (addr_ph || !rd)) begin
				if (addr_ph) begin
					got_addr = sh;
					rd = sh[0];
					active = !refuse && sh[7:1] == addr;
				end else begin
					got[8*idx +: 8] = sh;
					idx++;
				end
				addr_ph = 1'h0;
				sda_oe <= #(lag) active;
			end else if (bits == 8) begin
				sda_oe <= #(lag) 1'h0;
				idx++;
			end else if (bits == 9) begin
				bits = 0;
				sda_oe <= #(lag) rd && idx < 3 && !read_bytes[8*idx + 7];
			end else if (rd) begin
				sda_oe <= #(lag) !read_bytes[8*idx + 7 - bits];
			end
		end else begin
			sda_oe <= #(lag) 1'h0;
		end
	end
endmodule
